// ===== ssw_defines.vh
// timing counts, output modes and reset values for the supply supervisor
`ifndef SSW_DEFINES_VH
`define SSW_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define SSW_CLK_KHZ        10000
`define SSW_RST_HOLD_MS    140
`define SSW_RST_HOLD_CYC   (`SSW_RST_HOLD_MS * `SSW_CLK_KHZ)
`define SSW_WDOG_MS        1600
`define SSW_WDOG_CYC       (`SSW_WDOG_MS * `SSW_CLK_KHZ)
`define SSW_MR_GLITCH_NS   100
`define SSW_MR_FILT_CYC    ((`SSW_MR_GLITCH_NS * `SSW_CLK_KHZ + 999999) / 1000000)
`define SSW_KICK_FILT_CYC  0

// ****************************************
// reset output modes
// ****************************************
`define SSW_OUT_PP_LOW     2'h0
`define SSW_OUT_OD_LOW     2'h1
`define SSW_OUT_PP_HIGH    2'h2
`define SSW_OUT_PP_BOTH    2'h3

// ****************************************
// pin levels after chip reset
// ****************************************
`define SSW_SUPPLY_RST     1'b1
`define SSW_MR_RST         1'b1
`define SSW_KICK_RST       1'b0

`endif

// ===== ssw_host_model.sv
// host model that services the watchdog while out of reset
`default_nettype none
module ssw_host_model (
    input  wire logic sys_clk_i,
    input  wire logic reset_hi_i,
    input  wire logic kick_en_i,
    output var logic  kick_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_r = 3'h0;
    logic       kick_r = 1'h0;
    assign kick_o = kick_r;
    always @(posedge sys_clk_i) begin
        if (reset_hi_i || !kick_en_i) cnt_r <= 3'h0;
        else cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) kick_r <= ~kick_r;
    end
endmodule // ssw_host_model
`default_nettype wire

// ===== ssw_pin_filter.v
// three-stage pin synchroniser with stability filter and edge pulse
`default_nettype none

module ssw_pin_filter #(
    parameter       FILT_CYC = 0,
    parameter       CW       = 4,
    parameter [0:0] RST_VAL  = 1'b0
) (
    // clock and reset
    input  wire sys_clk_i,
    input  wire rst_n_i,
    // pin side
    input  wire pin_i,
    // filtered side
    output reg  level_o,
    output reg  edge_o
);

    reg          s1_r;
    reg          s2_r;
    reg          s3_r;
    reg [CW-1:0] cnt_r;

    // ****************************************
    // sync chain and filter
    // ****************************************
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r    <= RST_VAL;
            s2_r    <= RST_VAL;
            s3_r    <= RST_VAL;
            cnt_r   <= {CW{1'b0}};
            level_o <= RST_VAL;
            edge_o  <= 1'b0;
        end else begin
            s1_r   <= pin_i;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            edge_o <= 1'b0;
            if (s2_r == s3_r && s3_r != level_o) begin
                if (cnt_r >= FILT_CYC[CW-1:0]) begin
                    level_o <= s3_r;
                    edge_o  <= 1'b1;
                    cnt_r   <= {CW{1'b0}};
                end else begin
                    cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
                end
            end else begin
                cnt_r <= {CW{1'b0}};
            end
        end
    end

endmodule // ssw_pin_filter

`default_nettype wire

// ===== ssw_supervisor.v
// supply supervisor with reset hold timer, watchdog and manual reset
//
// What this block does
// - reset is asserted whenever the supply-low flag is true, whatever the watchdog or manual input do.
// - after the supply recovers, reset stays asserted for the hold period (140 ms min, 280 ms max) then releases.
// - the watchdog expires after a nominal 1.6 s without service and then forces a reset.
// - refresh levels are recognised once stable across two clock samples, with no extra filter; the host holds them.
// - a manual low of 1 us or more forces reset, a ~100 ns glitch is rejected, reset follows within a few cycles.
// - the reset output is built as active-low push-pull, active-low open-drain, active-high, or both polarities.
// - build options choose whether the watchdog and the manual input exist.
// - the watchdog count restarts on any refresh edge, any reset assertion and manual reset; the host must toggle.
// - the watchdog count is held at zero while reset is asserted and starts counting on release.
// - reset stays asserted while the manual input is low and for one hold period after it returns high.
`default_nettype none
`include "ssw_defines.vh"

module ssw_supervisor #(
    parameter [31:0] HOLD_CYC = `SSW_RST_HOLD_CYC,
    parameter [31:0] WDOG_CYC = `SSW_WDOG_CYC,
    parameter [1:0]  OUT_MODE = `SSW_OUT_PP_LOW,
    parameter        HAS_WDOG = 1,
    parameter        HAS_MR   = 1
) (
    // clock and reset
    input  wire sys_clk_i,
    input  wire rst_n_i,
    // monitored inputs
    input  wire supply_low_i,
    input  wire manual_reset_in_n_i,
    input  wire watchdog_kick_in_i,
    // reset outputs and watchdog expiry flag
    output reg  reset_n_o,
    output reg  reset_n_oe_o,
    output reg  reset_hi_o,
    output reg  wdog_expired_o
);

    localparam [1:0] ST_RUN  = 2'b01;
    localparam [1:0] ST_HOLD = 2'b10;

    // ****************************************
    // decode helpers
    // ****************************************
    function in_run;
        input [1:0] st;
        begin
            in_run = (st == ST_RUN);
        end
    endfunction

    function low_pin_used;
        input [1:0] mode;
        begin
            low_pin_used = (mode != `SSW_OUT_PP_HIGH);
        end
    endfunction

    function high_pin_used;
        input [1:0] mode;
        begin
            high_pin_used = (mode == `SSW_OUT_PP_HIGH) || (mode == `SSW_OUT_PP_BOTH);
        end
    endfunction

    localparam [0:0] LOW_OE_RST = low_pin_used(OUT_MODE);
    localparam [0:0] HIGH_RST   = high_pin_used(OUT_MODE);

    wire        supply_low;
    wire        mr_level;
    wire        kick_edge;
    wire        mr_low;
    wire        wd_exp;
    wire        cond;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [31:0] hold_cnt_r;
    reg  [31:0] hold_cnt_nxt;
    reg  [31:0] wd_cnt_r;
    reg  [31:0] wd_cnt_nxt;
    wire        asserted_nxt;

    // ****************************************
    // input conditioning
    // ****************************************
    ssw_pin_filter #(
        .FILT_CYC (0),
        .CW       (4),
        .RST_VAL  (`SSW_SUPPLY_RST)
    ) u_supply (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (supply_low_i),
        .level_o   (supply_low),
        .edge_o    ()
    );

    generate
        if (HAS_MR != 0) begin : g_mr
            ssw_pin_filter #(
                .FILT_CYC (`SSW_MR_FILT_CYC),
                .CW       (4),
                .RST_VAL  (`SSW_MR_RST)
            ) u_mr (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .pin_i     (manual_reset_in_n_i),
                .level_o   (mr_level),
                .edge_o    ()
            );
        end else begin : g_no_mr
            assign mr_level = 1'b1;
        end
        if (HAS_WDOG != 0) begin : g_wd
            ssw_pin_filter #(
                .FILT_CYC (`SSW_KICK_FILT_CYC),
                .CW       (4),
                .RST_VAL  (`SSW_KICK_RST)
            ) u_kick (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n_i),
                .pin_i     (watchdog_kick_in_i),
                .level_o   (),
                .edge_o    (kick_edge)
            );
            assign wd_exp = in_run(state_r) &&
                            !kick_edge &&
                            !mr_low &&
                            (wd_cnt_r == WDOG_CYC - 32'h1);
        end else begin : g_no_wd
            assign kick_edge = 1'b0;
            assign wd_exp    = 1'b0;
        end
    endgenerate

    assign mr_low = !mr_level;
    assign cond   = supply_low || mr_low || wd_exp;

    // ****************************************
    // reset state machine
    // ****************************************
    always @* begin
        state_nxt    = state_r;
        hold_cnt_nxt = hold_cnt_r;
        case (state_r)
            ST_RUN: begin
                if (cond) begin
                    state_nxt    = ST_HOLD;
                    hold_cnt_nxt = 32'h0;
                end
            end
            ST_HOLD: begin
                if (cond) begin
                    hold_cnt_nxt = 32'h0;
                end else if (hold_cnt_r == HOLD_CYC - 32'h1) begin
                    state_nxt    = ST_RUN;
                    hold_cnt_nxt = 32'h0;
                end else begin
                    hold_cnt_nxt = hold_cnt_r + 32'h1;
                end
            end
            default: begin
                state_nxt    = ST_HOLD;
                hold_cnt_nxt = 32'h0;
            end
        endcase
    end

    // ****************************************
    // watchdog counter
    // ****************************************
    always @* begin
        if (!in_run(state_r) || cond || kick_edge || mr_low) begin
            wd_cnt_nxt = 32'h0;
        end else begin
            wd_cnt_nxt = wd_cnt_r + 32'h1;
        end
    end

    assign asserted_nxt = (state_nxt == ST_HOLD);

    // ****************************************
    // registers and output drive
    // ****************************************
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r        <= ST_HOLD;
            hold_cnt_r     <= 32'h0;
            wd_cnt_r       <= 32'h0;
            wdog_expired_o <= 1'b0;
            reset_n_o      <= 1'b0;
            reset_n_oe_o   <= LOW_OE_RST;
            reset_hi_o     <= HIGH_RST;
        end else begin
            state_r        <= state_nxt;
            hold_cnt_r     <= hold_cnt_nxt;
            wd_cnt_r       <= wd_cnt_nxt;
            wdog_expired_o <= wd_exp;
            case (OUT_MODE)
                `SSW_OUT_OD_LOW: begin
                    reset_n_o    <= 1'b0;
                    reset_n_oe_o <= asserted_nxt;
                    reset_hi_o   <= 1'b0;
                end
                `SSW_OUT_PP_HIGH: begin
                    reset_n_o    <= 1'b0;
                    reset_n_oe_o <= 1'b0;
                    reset_hi_o   <= asserted_nxt;
                end
                `SSW_OUT_PP_BOTH: begin
                    reset_n_o    <= !asserted_nxt;
                    reset_n_oe_o <= 1'b1;
                    reset_hi_o   <= asserted_nxt;
                end
                default: begin
                    reset_n_o    <= !asserted_nxt;
                    reset_n_oe_o <= 1'b1;
                    reset_hi_o   <= 1'b0;
                end
            endcase
        end
    end

endmodule // ssw_supervisor

`default_nettype wire

// ===== ssw_supervisor_properties.sv
// port assertions for the supply supervisor
`default_nettype none
module ssw_chk #(parameter int HOLD_CYC = 20, parameter int WDOG_CYC = 50, parameter logic [1:0] OUT_MODE = 2'h3) (
    input wire logic sys_clk_i, rst_n_i, supply_low_i, manual_reset_in_n_i, watchdog_kick_in_i,
    input wire logic reset_n_o, reset_n_oe_o, reset_hi_o, wdog_expired_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    int   hi_r;
    int   qt_r;
    logic kq_r;
    logic rst_act;
    // reset asserted in whichever output mode is built
    assign rst_act = reset_hi_o || (reset_n_oe_o && !reset_n_o);
    // length of reset pulse and time without service
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_r <= 0;
            qt_r <= 0;
            kq_r <= 1'h0;
        end else begin
            hi_r <= rst_act ? hi_r + 1 : 0;
            qt_r <= (rst_act || watchdog_kick_in_i != kq_r) ? 0 : qt_r + 1;
            kq_r <= watchdog_kick_in_i;
        end
    end
    supply_trip_a: assert property (supply_low_i [*6] |-> rst_act) else $error("no reset on low supply");
    hold_min_a: assert property ($fell(rst_act) |-> hi_r >= HOLD_CYC) else $error("reset pulse short");
    manual_force_a: assert property (!manual_reset_in_n_i [*8] |-> rst_act) else $error("manual ignored");
    both_polarity_a: assert property ((OUT_MODE == 2'h3) |-> reset_n_o == !reset_hi_o)
        else $error("outputs disagree");
    push_pull_a: assert property ((OUT_MODE == 2'h0 || OUT_MODE == 2'h3) |-> reset_n_oe_o)
        else $error("low output not driven");
    open_drain_a: assert property ((OUT_MODE == 2'h1) |-> !reset_n_o && !reset_hi_o)
        else $error("open drain pin driven high");
    high_only_a: assert property ((OUT_MODE == 2'h2) |-> !reset_n_oe_o)
        else $error("unused low pin driven");
    wdog_pulse_a: assert property (wdog_expired_o |-> $rose(rst_act) ##1 !wdog_expired_o)
        else $error("expiry pulse wrong");
    wdog_early_a: assert property ($rose(wdog_expired_o) |-> qt_r >= WDOG_CYC - 4)
        else $error("watchdog fired early");
    wdog_late_a: assert property (!rst_act |-> qt_r <= WDOG_CYC + 5) else $error("watchdog fired late");
endmodule // ssw_chk
bind ssw_supervisor ssw_chk #(.HOLD_CYC(HOLD_CYC), .WDOG_CYC(WDOG_CYC), .OUT_MODE(OUT_MODE)) ssw_chk_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low_i),
    .manual_reset_in_n_i(manual_reset_in_n_i), .watchdog_kick_in_i(watchdog_kick_in_i),
    .reset_n_o(reset_n_o), .reset_n_oe_o(reset_n_oe_o), .reset_hi_o(reset_hi_o),
    .wdog_expired_o(wdog_expired_o));
`default_nettype wire

// ===== ssw_supervisor_tb_top.sv
// self-checking bench for the supply supervisor
`default_nettype none
module ssw_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 20;
    logic sys_clk_i = 1'h0, rst_n_i = 1'h0, supply_low_i = 1'h1, manual_n = 1'h1, kick_en = 1'h1;
    logic kick, reset_n_o, reset_n_oe_o, reset_hi_o, wdog_expired_o, wd_seen, exp_wd[$];
    int   n_errors = 0, checked = 0, cyc = 0, len = 0, exp_len[$];
    wire  [2:0] m_n, m_oe, m_hi;
    always #50 sys_clk_i = ~sys_clk_i;
    ssw_supervisor #(.HOLD_CYC(HOLD), .WDOG_CYC(50), .OUT_MODE(2'h3), .HAS_WDOG(1), .HAS_MR(1))
    ssw_supervisor_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low_i),
        .manual_reset_in_n_i(manual_n), .watchdog_kick_in_i(kick), .reset_n_o(reset_n_o),
        .reset_n_oe_o(reset_n_oe_o), .reset_hi_o(reset_hi_o), .wdog_expired_o(wdog_expired_o));
    ssw_host_model ssw_host_model_inst (.sys_clk_i(sys_clk_i), .reset_hi_i(reset_hi_o),
        .kick_en_i(kick_en), .kick_o(kick));
    // the other three output modes on the same inputs
    for (genvar m = 0; m < 3; m++) begin : g_mode
        ssw_supervisor #(.HOLD_CYC(HOLD), .WDOG_CYC(50), .OUT_MODE(2'(m)), .HAS_WDOG(1), .HAS_MR(1))
        ssw_supervisor_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low_i),
            .manual_reset_in_n_i(manual_n), .watchdog_kick_in_i(kick), .reset_n_o(m_n[m]),
            .reset_n_oe_o(m_oe[m]), .reset_hi_o(m_hi[m]), .wdog_expired_o());
    end
    always @(posedge sys_clk_i) begin
        if (rst_n_i) begin
            checked++;
            if ({m_n, m_oe, m_hi} !== {2'h0, !reset_hi_o, 1'h0, reset_hi_o, 1'h1, reset_hi_o, 2'h0}) begin
                n_errors++;
                $display("mismatch output modes expected %b seen %b",
                    {2'h0, !reset_hi_o, 1'h0, reset_hi_o, 1'h1, reset_hi_o, 2'h0}, {m_n, m_oe, m_hi});
            end
        end
    end
    task automatic give_verdict;
        if (exp_len.size() != 0) begin
            n_errors++;
            $display("mismatch reset pulse expected %0d seen none", exp_len[0]);
        end
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic note(int l, logic wd);
        exp_len.push_back(l);
        exp_wd.push_back(wd);
    endtask
    task automatic settle;
        repeat (300) @(posedge sys_clk_i) if (exp_len.size() == 0 && len == 0) break;
    endtask
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    // measure each reset pulse and compare with the oldest note
    always @(posedge sys_clk_i) begin
        if (rst_n_i && reset_hi_o === 1'h1) begin
            if (len == 0) wd_seen = wdog_expired_o;
            len++;
        end else if (rst_n_i && len > 0) begin
            checked++;
            if (exp_len.size() == 0) begin
                n_errors++;
                $display("mismatch reset pulse expected none seen %0d", len);
            end else begin
                if (len < exp_len[0] || len > exp_len[0] + 8 || wd_seen !== exp_wd[0]) begin
                    n_errors++;
                    $display("mismatch reset pulse expected %0d %b seen %0d %b", exp_len[0], exp_wd[0], len, wd_seen);
                end
                void'(exp_len.pop_front());
                void'(exp_wd.pop_front());
            end
            len = 0;
        end
    end
    initial begin
        int l;
        void'($urandom(52019));
        note(HOLD, 1'h0);
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        @(posedge sys_clk_i) supply_low_i <= 1'h0;
        settle();
        repeat (200) @(posedge sys_clk_i);
        for (int i = 0; i < 3; i++) begin
            l = 5 + $urandom % 20;
            note(l + HOLD - 2, 1'h0);
            @(posedge sys_clk_i) supply_low_i <= 1'h1;
            repeat (l) @(posedge sys_clk_i);
            supply_low_i <= 1'h0;
            settle();
        end
        note(HOLD - 1, 1'h1);
        kick_en <= 1'h0;
        settle();
        kick_en <= 1'h1;
        note(HOLD + 6, 1'h0);
        manual_n <= 1'h0;
        repeat (10) @(posedge sys_clk_i);
        manual_n <= 1'h1;
        settle();
        manual_n <= 1'h0;
        @(posedge sys_clk_i) manual_n <= 1'h1;
        repeat (40) @(posedge sys_clk_i);
        give_verdict();
    end
endmodule // ssw_supervisor_tb_top
`default_nettype wire
